// ===== rtl/dle_led_encoder.sv
// Purpose: Map fieldbus, safety, drive and firmware state onto LED patterns
// Assumes: State inputs synchronous to core_clk; AXI4-Lite slave for control
// Notes: LED outputs are registered, one cycle behind their inputs
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
module dle_led_encoder #(
  parameter int unsigned TICK_CYCLES = dle_pkg::TICK_CYCLES
) (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input dle_pkg::dle_ecat_state_t ecat_state, // EtherCAT device state
  input dle_pkg::dle_ecat_err_t ecat_err, // EtherCAT error kind
  input wire logic pn_link, // PROFINET network connection present
  input wire logic pn_exchange, // PROFINET data exchange active
  input dle_pkg::dle_pn_run_t pn_run, // PROFINET connection phase
  input dle_pkg::dle_fsoe_state_t fsoe_state, // Safety communication state
  input wire logic [2:0] fsoe_err, // 0 none, 1..6 coded, 7 undefined
  input wire logic supply_ok, // Supply voltage present
  input wire logic safe_torque_off, // Safe torque off active
  input wire logic axis_ready, // At least one axis ready to switch on
  input wire logic axis_enabled, // At least one axis enabled
  input wire logic mem_writing, // Writing internal memory
  input wire logic [1:0] axis_warn, // Warning per axis
  input wire logic [1:0] axis_fault, // Fault per axis
  input wire logic [1:0] axis_nocfg, // No configuration active per axis
  input wire logic fw_starting, // Firmware start-up phase
  input dle_pkg::dle_fw_phase_t fw_phase, // Firmware update phase
  output logic bus_err_led, // Fieldbus red LED
  output logic bus_run_led, // Fieldbus green LED
  output logic safety_led, // Safety communication green LED
  output logic drive_run_led, // Drive green LED
  output logic [1:0] axis_err_led, // Red LED per axis
  output logic irq // Level interrupt
);

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] ctrl;
    logic [dle_pkg::IRQ_W-1:0] irq_stat;
    logic [dle_pkg::IRQ_W-1:0] irq_mask;
    logic [dle_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic [6:0] frame;
    logic [1:0] chase;
    dle_pkg::dle_ecat_state_t prev_ecat;
    logic prev_fs_err;
    logic prev_fault;
    logic prev_failed;
    logic [5:0] leds;
  } dle_state_t;

  dle_state_t s_q;
  dle_state_t s_d;
  logic [1:0] axis_pat;

  localparam logic [dle_pkg::TICK_CNT_W-1:0] TICK_LAST =
    dle_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

  // N flashes of one slot each, then dark until the frame ends
  function automatic logic nflash(input logic [6:0] fr, input logic [2:0] n);
    nflash = (fr < {1'b0, n, 3'b000}) && !fr[dle_pkg::FLASH_BIT];
  endfunction

  function automatic logic flash(input logic [6:0] fr);
    flash = !fr[dle_pkg::FLASH_BIT];
  endfunction

  function automatic logic rapid(input logic [6:0] fr);
    rapid = !fr[0];
  endfunction

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign bus_err_led = s_q.leds[0];
  assign bus_run_led = s_q.leds[1];
  assign safety_led = s_q.leds[2];
  assign drive_run_led = s_q.leds[3];
  assign axis_err_led = s_q.leds[5:4];
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // Per-axis error pattern; axis B is dark unless the build is dual-axis
  for (genvar a = 0; a < 2; a++) begin : g_axis
    always_comb begin
      if (a == 1 && !s_q.ctrl[dle_pkg::CTRL_DUAL]) begin
        axis_pat[a] = 1'b0;
      end else if (axis_nocfg[a]) begin
        axis_pat[a] = rapid(s_q.frame);
      end else if (axis_fault[a]) begin
        axis_pat[a] = 1'b1;
      end else if (axis_warn[a]) begin
        axis_pat[a] = flash(s_q.frame);
      end else begin
        axis_pat[a] = 1'b0;
      end
    end
  end

  always_comb begin
    logic tick;
    logic do_wr;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_val;
    logic [dle_pkg::IRQ_W-1:0] ev;
    logic [dle_pkg::IRQ_W-1:0] clr;
    logic fs_err;
    logic any_fault;
    logic failed;
    logic [6:0] fr;
    logic l_err;
    logic l_run;
    logic l_saf;
    logic l_drv;
    logic [1:0] l_ax;
    tick = 1'b0;
    do_wr = 1'b0;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    rd_val = 32'h0000_0000;
    ev = '0;
    clr = '0;
    fs_err = 1'b0;
    any_fault = 1'b0;
    failed = 1'b0;
    fr = s_q.frame;
    l_err = 1'b0;
    l_run = 1'b0;
    l_saf = 1'b0;
    l_drv = 1'b0;
    l_ax = 2'b00;
    s_d = s_q;

    // Shared timebase: tick, pattern frame and chaser position
    tick = (s_q.tick_cnt == TICK_LAST);
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
    if (tick) begin
      s_d.frame = (s_q.frame == dle_pkg::FRAME_LAST) ? 7'h00 : s_q.frame + 7'h01;
      if (s_q.frame[1:0] == dle_pkg::CHASE_STEP) begin
        s_d.chase = (s_q.chase == dle_pkg::CHASE_LAST) ? 2'h0 : s_q.chase + 2'h1;
      end
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    do_wr = s_q.aw_got && s_q.w_got;
    if (do_wr) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      case (s_q.aw_addr)
        dle_pkg::OFS_CTRL: begin
          wr_ok = 1'b1;
          if (s_q.w_strb[0]) begin
            s_d.ctrl = s_q.w_data[2:0];
          end
        end
        dle_pkg::OFS_STATUS: wr_ok = 1'b1;
        dle_pkg::OFS_IRQ_STAT: begin
          wr_ok = 1'b1;
          if (s_q.w_strb[0]) begin
            clr = s_q.w_data[dle_pkg::IRQ_W-1:0];
          end
        end
        dle_pkg::OFS_IRQ_MASK: begin
          wr_ok = 1'b1;
          if (s_q.w_strb[0]) begin
            s_d.irq_mask = s_q.w_data[dle_pkg::IRQ_W-1:0];
          end
        end
        default: wr_ok = 1'b0;
      endcase
      s_d.bresp = wr_ok ? dle_pkg::RESP_OKAY : dle_pkg::RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Read channel: one cycle to data
    if (s_axi_arvalid && s_axi_arready) begin
      case (s_axi_araddr)
        dle_pkg::OFS_CTRL: begin
          rd_ok = 1'b1;
          rd_val[2:0] = s_q.ctrl;
        end
        dle_pkg::OFS_STATUS: begin
          rd_ok = 1'b1;
          rd_val[dle_pkg::ST_ECAT_LSB +: 2] = ecat_state;
          rd_val[dle_pkg::ST_ECERR_LSB +: 2] = ecat_err;
          rd_val[dle_pkg::ST_PN_LSB +: 3] = pn_run;
          rd_val[dle_pkg::ST_FSOE_LSB +: 3] = fsoe_state;
          rd_val[dle_pkg::ST_FSERR_LSB +: 3] = fsoe_err;
          rd_val[dle_pkg::ST_LED_LSB +: 6] = s_q.leds;
        end
        dle_pkg::OFS_IRQ_STAT: begin
          rd_ok = 1'b1;
          rd_val[dle_pkg::IRQ_W-1:0] = s_q.irq_stat;
        end
        dle_pkg::OFS_IRQ_MASK: begin
          rd_ok = 1'b1;
          rd_val[dle_pkg::IRQ_W-1:0] = s_q.irq_mask;
        end
        default: rd_ok = 1'b0;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_ok ? dle_pkg::RESP_OKAY : dle_pkg::RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // Events: a new event in the clearing cycle is kept
    fs_err = (fsoe_err != dle_pkg::FSERR_NONE) && s_q.ctrl[dle_pkg::CTRL_SAFETY];
    any_fault = |axis_fault;
    failed = (fw_phase == dle_pkg::FW_FAILED);
    ev[dle_pkg::IRQ_ECAT_CHG] = (ecat_state != s_q.prev_ecat);
    ev[dle_pkg::IRQ_FSOE_ERR] = fs_err && !s_q.prev_fs_err;
    ev[dle_pkg::IRQ_AXIS_FAULT] = any_fault && !s_q.prev_fault;
    ev[dle_pkg::IRQ_FW_FAIL] = failed && !s_q.prev_failed;
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
    s_d.prev_ecat = ecat_state;
    s_d.prev_fs_err = fs_err;
    s_d.prev_fault = any_fault;
    s_d.prev_failed = failed;

    // Fieldbus LEDs, selected by bus type
    if (!s_q.ctrl[dle_pkg::CTRL_BUS_SEL]) begin
      case (ecat_err)
        dle_pkg::ECERR_NONE: l_err = 1'b0;
        dle_pkg::ECERR_BAD_CFG: l_err = flash(fr);
        dle_pkg::ECERR_UNSOL: l_err = nflash(fr, 3'h1);
        dle_pkg::ECERR_WDOG: l_err = nflash(fr, 3'h2);
        default: l_err = 1'b0;
      endcase
      case (ecat_state)
        dle_pkg::ECAT_INIT: l_run = 1'b0;
        dle_pkg::ECAT_PREOP: l_run = flash(fr);
        dle_pkg::ECAT_SAFEOP: l_run = nflash(fr, 3'h1);
        dle_pkg::ECAT_OP: l_run = 1'b1;
        default: l_run = 1'b0;
      endcase
    end else begin
      if (!pn_link) begin
        l_err = 1'b1;
      end else if (!pn_exchange) begin
        l_err = rapid(fr);
      end else begin
        l_err = 1'b0;
      end
      case (pn_run)
        dle_pkg::PN_NONE: l_run = 1'b0;
        dle_pkg::PN_SETUP: l_run = nflash(fr, 3'h1);
        dle_pkg::PN_DHCP: l_run = !nflash(fr, 3'h1);
        dle_pkg::PN_EXPECT: l_run = flash(fr);
        dle_pkg::PN_ESTAB: l_run = 1'b1;
        default: l_run = 1'b0;
      endcase
    end

    // Safety communication LED; dark when no safety module fitted
    if (!s_q.ctrl[dle_pkg::CTRL_SAFETY]) begin
      l_saf = 1'b0;
    end else if (fsoe_err == dle_pkg::FSERR_UNDEF) begin
      l_saf = rapid(fr);
    end else if (fsoe_err != dle_pkg::FSERR_NONE) begin
      l_saf = (fr < dle_pkg::RAPID_START) ? nflash(fr, fsoe_err) : rapid(fr);
    end else begin
      case (fsoe_state)
        dle_pkg::FS_PRE_RESET: l_saf = 1'b0;
        dle_pkg::FS_RESET, dle_pkg::FS_SESSION, dle_pkg::FS_CONN,
        dle_pkg::FS_PARAM: l_saf = flash(fr);
        dle_pkg::FS_PROCESS: l_saf = 1'b1;
        dle_pkg::FS_FAILSAFE: l_saf = nflash(fr, 3'h1);
        default: l_saf = 1'b0;
      endcase
    end

    // Drive run LED, normal meaning
    if (mem_writing) begin
      l_drv = rapid(fr);
    end else if (!supply_ok || any_fault) begin
      l_drv = 1'b0;
    end else if (axis_enabled) begin
      l_drv = 1'b1;
    end else if (axis_ready) begin
      l_drv = flash(fr);
    end else if (safe_torque_off) begin
      l_drv = nflash(fr, 3'h1);
    end else begin
      l_drv = 1'b0;
    end
    l_ax = axis_pat;

    // Start-up and update phases override the drive LEDs
    if (fw_starting) begin
      l_drv = 1'b1;
      l_ax = 2'b11;
    end else begin
      case (fw_phase)
        dle_pkg::FW_ERASE: begin
          l_drv = 1'b0;
          l_ax = {1'b0, rapid(fr)};
        end
        dle_pkg::FW_COPY: begin
          l_drv = rapid(fr);
          l_ax = 2'b00;
        end
        dle_pkg::FW_FAILED: begin
          l_drv = (s_q.chase == 2'h0);
          l_ax = {s_q.chase == 2'h2, s_q.chase == 2'h1};
        end
        default: ; // Normal meanings stay
      endcase
    end
    s_d.leds = {l_ax, l_drv, l_saf, l_run, l_err};
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ===== rtl/dle_pkg.sv
// Purpose: Shared constants and types of the diagnostic LED pattern encoder
// Assumes: 100 MHz core clock, AXI4-Lite register access
// Notes: Blink timing is built from one tick; all periods count in ticks
package dle_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_US = 50;
  localparam int unsigned TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 16;
  localparam logic [6:0] FRAME_LAST = 7'h4f;
  localparam logic [6:0] FLASH_SLOT = 7'h08;
  localparam logic [6:0] RAPID_START = 7'h38;
  localparam int unsigned FLASH_BIT = 2;
  localparam logic [1:0] CHASE_LAST = 2'h2;
  localparam logic [1:0] CHASE_STEP = 2'h3;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;

  localparam int unsigned CTRL_BUS_SEL = 0;
  localparam int unsigned CTRL_SAFETY = 1;
  localparam int unsigned CTRL_DUAL = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  localparam int unsigned ST_ECAT_LSB = 0;
  localparam int unsigned ST_ECERR_LSB = 2;
  localparam int unsigned ST_PN_LSB = 4;
  localparam int unsigned ST_FSOE_LSB = 8;
  localparam int unsigned ST_FSERR_LSB = 12;
  localparam int unsigned ST_LED_LSB = 16;

  localparam int unsigned IRQ_ECAT_CHG = 0;
  localparam int unsigned IRQ_FSOE_ERR = 1;
  localparam int unsigned IRQ_AXIS_FAULT = 2;
  localparam int unsigned IRQ_FW_FAIL = 3;
  localparam int unsigned IRQ_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ECAT_INIT = 2'b00, ECAT_PREOP = 2'b01, ECAT_SAFEOP = 2'b10, ECAT_OP = 2'b11
  } dle_ecat_state_t;

  typedef enum logic [1:0] {
    ECERR_NONE = 2'b00, ECERR_BAD_CFG = 2'b01, ECERR_UNSOL = 2'b10, ECERR_WDOG = 2'b11
  } dle_ecat_err_t;

  typedef enum logic [2:0] {
    PN_NONE = 3'b000, PN_SETUP = 3'b001, PN_DHCP = 3'b010, PN_EXPECT = 3'b011,
    PN_ESTAB = 3'b100
  } dle_pn_run_t;

  typedef enum logic [2:0] {
    FS_PRE_RESET = 3'b000, FS_RESET = 3'b001, FS_SESSION = 3'b010, FS_CONN = 3'b011,
    FS_PARAM = 3'b100, FS_PROCESS = 3'b101, FS_FAILSAFE = 3'b110
  } dle_fsoe_state_t;

  localparam logic [2:0] FSERR_NONE = 3'h0;
  localparam logic [2:0] FSERR_UNDEF = 3'h7;

  typedef enum logic [1:0] {
    FW_NORMAL = 2'b00, FW_ERASE = 2'b01, FW_COPY = 2'b10, FW_FAILED = 2'b11
  } dle_fw_phase_t;
endpackage

// ===== tb/dle_led_encoder_assertions.sv
// Purpose: Port-level checks of the LED pattern encoder
// Assumes: One clock domain, bound to every encoder instance
// Notes: LED checks allow for the one-cycle output register
module dle_led_encoder_chk #(
  parameter int unsigned TICK_CYCLES = dle_pkg::TICK_CYCLES
) (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic supply_ok, // Supply present
  input wire logic axis_enabled, // Axis enabled
  input wire logic mem_writing, // Memory write
  input wire logic [1:0] axis_warn, // Warnings
  input wire logic [1:0] axis_fault, // Faults
  input wire logic [1:0] axis_nocfg, // No configuration
  input wire logic fw_starting, // Start-up
  input dle_pkg::dle_fw_phase_t fw_phase, // Update phase
  input wire logic drive_run_led, // Drive LED
  input wire logic [1:0] axis_err_led, // Axis LEDs
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nrm;
  assign nrm = !fw_starting && fw_phase == dle_pkg::FW_NORMAL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_start;
    fw_starting |=> drive_run_led && axis_err_led == 2'h3;
  endproperty
  a_start: assert property (p_start) else $error("start-up pattern wrong");
  property p_erase;
    !fw_starting && fw_phase == dle_pkg::FW_ERASE |=> !drive_run_led && !axis_err_led[1];
  endproperty
  a_erase: assert property (p_erase) else $error("erase pattern wrong");
  property p_copy;
    !fw_starting && fw_phase == dle_pkg::FW_COPY |=> axis_err_led == 2'h0;
  endproperty
  a_copy: assert property (p_copy) else $error("copy pattern wrong");
  property p_chase;
    !fw_starting && fw_phase == dle_pkg::FW_FAILED |=> $onehot({drive_run_led, axis_err_led});
  endproperty
  a_chase: assert property (p_chase) else $error("chaser not one-hot");
  property p_drv_off;
    nrm && !mem_writing && (!supply_ok || axis_fault != 2'h0) |=> !drive_run_led;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("drive LED lit");
  property p_drv_on;
    nrm && !mem_writing && supply_ok && axis_fault == 2'h0 && axis_enabled |=> drive_run_led;
  endproperty
  a_drv_on: assert property (p_drv_on) else $error("drive LED dark");
  property p_ax_fault;
    nrm && !axis_nocfg[0] && axis_fault[0] |=> axis_err_led[0];
  endproperty
  a_ax_fault: assert property (p_ax_fault) else $error("fault LED dark");
  property p_ax_ok;
    nrm && {axis_warn[0], axis_fault[0], axis_nocfg[0]} == 3'h0 |=> !axis_err_led[0];
  endproperty
  a_ax_ok: assert property (p_ax_ok) else $error("axis LED lit");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_chase: cover property (fw_phase == dle_pkg::FW_FAILED && drive_run_led);
  c_irq: cover property (irq);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == dle_pkg::RESP_SLVERR);
endmodule
bind dle_led_encoder dle_led_encoder_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk,
  .reset_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .supply_ok,
  .axis_enabled, .mem_writing, .axis_warn, .axis_fault, .axis_nocfg, .fw_starting, .fw_phase,
  .drive_run_led, .axis_err_led, .irq);

// ===== tb/dle_panel_model.sv
// Purpose: Operator view of the front panel over one pattern frame
// Assumes: FRAME equals the encoder frame length in clock cycles
// Notes: A whole frame is watched, so counts of patterns that repeat each frame do not depend on phase
module dle_panel_model #(
  parameter int FRAME = 320
) (
  input wire logic core_clk, // Clock
  input wire logic start, // Begin watching
  input wire logic [5:0] leds, // {axB, axA, drv, saf, run, err}
  output logic busy, // Watching
  output logic [5:0][8:0] on_cnt, // Lit cycles per LED
  output logic [5:0][8:0] tg_cnt, // Changes per LED
  output logic [8:0] one_cnt // Cycles with one drive LED lit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] left;
  logic [5:0] last;
  initial busy = 1'b0;
  always @(posedge core_clk) begin
    if (start) begin
      busy <= 1'b1;
      left <= 9'(FRAME);
      on_cnt <= '0;
      tg_cnt <= '0;
      one_cnt <= '0;
      last <= leds;
    end else if (busy) begin
      for (int i = 0; i < 6; i++) begin
        on_cnt[i] <= on_cnt[i] + 9'(leds[i]);
        tg_cnt[i] <= tg_cnt[i] + 9'(leds[i] != last[i]);
      end
      one_cnt <= one_cnt + 9'($onehot(leds[5:3]));
      last <= leds;
      left <= left - 9'h1;
      busy <= (left != 9'h1);
    end
  end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the LED pattern encoder
// Assumes: Tick shortened to TK cycles, frame of 80 ticks
// Notes: Patterns are judged by lit and change counts over one frame
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam int FR = 80 * TK;
  localparam int FL = 40 * TK;
  localparam int S1 = 4 * TK;
  localparam int EEX[4] = '{0, FL, S1, 2 * S1};
  localparam int ECX[4] = '{0, FL, S1, FR};
  localparam int ETX[4] = '{0, 20, 2, 0};
  localparam int PRX[5] = '{0, S1, FR - S1, FL, FR};
  localparam int PEX[5] = '{FR, FL, 0, 0, 0};
  localparam int PET[5] = '{0, 80, 0, 0, 0};
  localparam int SFX[7] = '{0, FL, FL, FL, FL, FR, S1};
  localparam logic [10:0] DV[6] = '{11'h000, 11'h610, 11'h720, 11'h583, 11'h484, 11'h448};
  localparam int DRX[6] = '{0, S1, FL, FR, 0, FL};
  localparam int DRT[6] = '{0, 2, 20, 0, 0, 80};
  localparam int AAX[6] = '{0, FL, 0, FL, FR, 0};
  localparam int ABX[6] = '{0, 0, FL, FL, 0, FR};
  localparam int FWD[3] = '{FR, 0, FL};
  localparam int FWT[3] = '{0, 0, 80};
  localparam int FWA[3] = '{FR, FL, 0};
  localparam int FWB[3] = '{FR, 0, 0};
  logic core_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, axis_warn, axis_fault, axis_nocfg, axis_err_led;
  dle_pkg::dle_ecat_state_t ecat_state;
  dle_pkg::dle_ecat_err_t ecat_err;
  dle_pkg::dle_pn_run_t pn_run;
  dle_pkg::dle_fsoe_state_t fsoe_state;
  dle_pkg::dle_fw_phase_t fw_phase;
  logic [2:0] fsoe_err;
  logic pn_link, pn_exchange, supply_ok, safe_torque_off, axis_ready, axis_enabled, mem_writing;
  logic fw_starting, bus_err_led, bus_run_led, safety_led, drive_run_led, irq, start, busy;
  logic [5:0][8:0] on_cnt, tg_cnt;
  logic [8:0] one_cnt;
  int err_total, compares, cyc, e;
  dle_led_encoder #(.TICK_CYCLES(TK)) uut (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ecat_state, .ecat_err, .pn_link, .pn_exchange,
    .pn_run, .fsoe_state, .fsoe_err, .supply_ok, .safe_torque_off, .axis_ready, .axis_enabled,
    .mem_writing, .axis_warn, .axis_fault, .axis_nocfg, .fw_starting, .fw_phase, .bus_err_led,
    .bus_run_led, .safety_led, .drive_run_led, .axis_err_led, .irq);
  dle_panel_model #(.FRAME(FR)) u_panel (.core_clk, .start, .busy, .on_cnt, .tg_cnt, .one_cnt,
    .leds({axis_err_led, drive_run_led, safety_led, bus_run_led, bus_err_led}));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Counts: compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Ready and answer are sampled mid-cycle, where they equal their value at the next edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ga, gw, gb;
    int n;
    n = 0;
    gb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!gb && n < 50) begin
      @(negedge core_clk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      n++;
    end
    if (!gb) chk(32'h0, 32'h1);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ga, gr;
    int n;
    n = 0;
    gr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!gr && n < 50) begin
      @(negedge core_clk);
      ga = s_axi_arvalid && s_axi_arready;
      gr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ga) s_axi_arvalid <= 1'b0;
      n++;
    end
    if (!gr) chk(32'h0, 32'h1);
  endtask
  task automatic look();
    repeat (3) @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    while (busy) @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    {reset_n, start, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h31;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fsoe_err} = '0;
    {pn_link, pn_exchange, supply_ok, safe_torque_off, axis_ready, axis_enabled} = '0;
    {mem_writing, fw_starting, axis_warn, axis_fault, axis_nocfg} = '0;
    ecat_state = dle_pkg::ECAT_INIT;
    ecat_err = dle_pkg::ECERR_NONE;
    pn_run = dle_pkg::PN_NONE;
    fsoe_state = dle_pkg::FS_PRE_RESET;
    fw_phase = dle_pkg::FW_NORMAL;
    err_total = 0;
    compares = 0;
    cyc = 0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    axr(dle_pkg::OFS_CTRL, rd, rr);
    chk(rd, 32'h0);
    axr(8'h10, rd, rr);
    chk({rd[31:2], rr}, {30'h0, dle_pkg::RESP_SLVERR});
    axw(8'h10, 32'h1, rr);
    chk({30'h0, rr}, {30'h0, dle_pkg::RESP_SLVERR});
    axw(dle_pkg::OFS_IRQ_MASK, 32'h1, rr);
    for (int i = 0; i < 4; i++) begin
      ecat_state <= dle_pkg::dle_ecat_state_t'(i);
      ecat_err <= dle_pkg::dle_ecat_err_t'(i);
      look();
      chk(32'(on_cnt[0]), EEX[i]);
      chk(32'(on_cnt[1]), ECX[i]);
      chk(32'(tg_cnt[1]), ETX[i]);
      axr(dle_pkg::OFS_STATUS, rd, rr);
      chk({28'h0, rd[3:0]}, 32'(5 * i));
    end
    chk({31'h0, irq}, 32'h1);
    axr(dle_pkg::OFS_IRQ_STAT, rd, rr);
    chk(rd, 32'h1);
    axw(dle_pkg::OFS_IRQ_STAT, 32'h1, rr);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    @(posedge core_clk);
    axw(dle_pkg::OFS_IRQ_MASK, 32'h0, rr);
    ecat_state <= dle_pkg::ECAT_INIT;
    look();
    chk({31'h0, irq}, 32'h0);
    $display("Test fieldbus A done");
    axw(dle_pkg::OFS_CTRL, 32'h1, rr);
    for (int i = 0; i < 5; i++) begin
      pn_run <= dle_pkg::dle_pn_run_t'(i);
      pn_link <= (i != 0);
      pn_exchange <= (i > 1);
      look();
      chk(32'(on_cnt[1]), PRX[i]);
      chk(32'(on_cnt[0]), PEX[i]);
      chk(32'(tg_cnt[0]), PET[i]);
    end
    $display("Test fieldbus B done");
    axw(dle_pkg::OFS_CTRL, 32'h2, rr);
    for (int i = 0; i < 14; i++) begin
      fsoe_state <= dle_pkg::dle_fsoe_state_t'((i < 7) ? i : 4);
      fsoe_err <= (i < 7) ? 3'h0 : 3'(i - 6);
      e = (i < 7) ? SFX[i] : (i == 13) ? FL : (4 * i - 12) * TK;
      look();
      chk(32'(on_cnt[2]), e);
    end
    axw(dle_pkg::OFS_CTRL, 32'h4, rr);
    look();
    chk(32'(on_cnt[2]), 32'h0);
    $display("Test safety done");
    for (int i = 0; i < 6; i++) begin
      {supply_ok, safe_torque_off, axis_ready, axis_enabled, mem_writing, axis_warn,
        axis_fault, axis_nocfg} <= DV[i];
      look();
      chk(32'(on_cnt[3]), DRX[i]);
      chk(32'(tg_cnt[3]), DRT[i]);
      chk(32'(on_cnt[4]), AAX[i]);
      chk(32'(on_cnt[5]), ABX[i]);
    end
    axw(dle_pkg::OFS_CTRL, 32'h0, rr);
    axis_fault <= 2'h3;
    look();
    chk(32'(on_cnt[4]), FR);
    chk(32'(on_cnt[5]), 32'h0);
    $display("Test drive done");
    for (int i = 0; i < 3; i++) begin
      fw_starting <= (i == 0);
      fw_phase <= dle_pkg::dle_fw_phase_t'(i);
      look();
      chk(32'(on_cnt[3]), FWD[i]);
      chk(32'(tg_cnt[3]), FWT[i]);
      chk(32'(on_cnt[4]), FWA[i]);
      chk(32'(on_cnt[5]), FWB[i]);
    end
    fw_phase <= dle_pkg::FW_FAILED;
    look();
    chk(32'(one_cnt), FR);
    chk({31'h0, on_cnt[5] != 9'h0}, 32'h1);
    fw_phase <= dle_pkg::FW_NORMAL;
    look();
    chk(32'(on_cnt[3]), FL);
    $display("Test firmware done");
    complete_run();
  end
endmodule
